// ---- ssp_ssi_slave.sv ----
`include "ssp_map.svh"

module ssp_ssi_slave
   import ssp_pkg::*;
#(
   parameter int RES_UM = 1,
   parameter ssp_code_t CODE = SSP_CODE_GRAY,
   localparam int W = ssp_word_len(RES_UM)
)
(
   // System side
   input wire logic clk_sys,
   input wire logic reset,
   // Sensor side
   input wire logic [W-2:0] position,
   input wire logic read_fault,
   input wire logic speed_fault,
   // Status
   output logic ready,
   // Link
   ssp_link_if.dev link
);

   localparam int MONO_CYC = `SSP_MONOFLOP_US * `SSP_CLK_SYS_MHZ;
   localparam int MW = $clog2(MONO_CYC + 1);
   localparam int CW = $clog2(`SSP_LINK_CLR_CYC + 1);
   localparam int IW = $clog2(W + 1);

   // Gray to binary, used when the build sends plain binary
   function automatic logic [W-2:0] gray_to_bin(input logic [W-2:0] g);
      logic [W-2:0] b;
      b = '0;
      b[W-2] = g[W-2];
      for (int i = W - 3; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // ***************************************
   // Position snapshot
   // ***************************************
   // Kept in Gray so that a read at an unrelated link edge sees at most
   // one changing bit while the count moves by one step.
   logic [W-2:0] gray_q;
   logic ok_q;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         gray_q <= '0;
         ok_q <= 1'b0;
      end
      else
      begin
         gray_q <= position ^ (position >> 1);
         ok_q <= ~(read_fault | speed_fault);
      end
   end

   // ***************************************
   // Link activity into the system domain
   // ***************************************
   logic act_s1_q;
   logic act_s2_q;
   logic act_s3_q;
   logic act_edge;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         act_s1_q <= `SSP_LINK_IDLE;
         act_s2_q <= `SSP_LINK_IDLE;
         act_s3_q <= `SSP_LINK_IDLE;
      end
      else
      begin
         act_s1_q <= link.sclk;
         act_s2_q <= act_s1_q;
         act_s3_q <= act_s2_q;
      end
   end

   assign act_edge = act_s2_q ^ act_s3_q;

   // ***************************************
   // Monoflop
   // ***************************************
   // Retriggered by every link clock edge; expires one interval after
   // the last edge of the burst.
   logic [MW-1:0] mono_cnt_q;
   logic mono_run_q;
   logic mono_done;

   assign mono_done = mono_run_q && (mono_cnt_q == '0);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         mono_run_q <= 1'b0;
         mono_cnt_q <= '0;
      end
      else if (act_edge)
      begin
         mono_run_q <= 1'b1;
         mono_cnt_q <= MW'(MONO_CYC - 1);
      end
      else if (mono_done)
      begin
         mono_run_q <= 1'b0;
      end
      else if (mono_run_q)
      begin
         mono_cnt_q <= mono_cnt_q - 1'b1;
      end
   end

   // ***************************************
   // Link clear and ready
   // ***************************************
   // The clear resets the link logic only while the link clock is still,
   // which the pause between bursts guarantees.
   logic [CW-1:0] clr_cnt_q;
   logic link_clr_q;
   logic ready_q;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         clr_cnt_q <= CW'(`SSP_LINK_CLR_CYC);
      end
      else if (mono_done)
      begin
         clr_cnt_q <= CW'(`SSP_LINK_CLR_CYC);
      end
      else if (clr_cnt_q != '0)
      begin
         clr_cnt_q <= clr_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         link_clr_q <= 1'b1;
      end
      else
      begin
         link_clr_q <= (clr_cnt_q != '0) || mono_done;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ready_q <= 1'b0;
      end
      else if (act_edge)
      begin
         ready_q <= 1'b0;
      end
      // Ready only once the clear is released, so no burst meets an active clear
      else if (!link_clr_q && !mono_run_q && (clr_cnt_q == '0))
      begin
         ready_q <= 1'b1;
      end
   end

   assign ready = ready_q;

   // ***************************************
   // Capture on the falling link edge
   // ***************************************
   logic armed_q;
   logic [W-1:0] cap_q;

   always_ff @(negedge link.sclk or posedge link_clr_q)
   begin
      if (link_clr_q)
      begin
         armed_q <= 1'b1;
      end
      else
      begin
         armed_q <= 1'b0;
      end
   end

   always_ff @(negedge link.sclk or posedge link_clr_q)
   begin
      if (link_clr_q)
      begin
         cap_q <= '0;
      end
      else if (armed_q)
      begin
         if (CODE == SSP_CODE_GRAY)
         begin
            cap_q <= {gray_q, ok_q};
         end
         else
         begin
            cap_q <= {gray_to_bin(gray_q), ok_q};
         end
      end
   end

   // ***************************************
   // Shift out on the rising link edge
   // ***************************************
   logic [IW-1:0] idx_q;
   logic sdata_q;

   always_ff @(posedge link.sclk or posedge link_clr_q)
   begin
      if (link_clr_q)
      begin
         idx_q <= '0;
      end
      else if (idx_q < IW'(W))
      begin
         idx_q <= idx_q + 1'b1;
      end
   end

   always_ff @(posedge link.sclk or posedge link_clr_q)
   begin
      if (link_clr_q)
      begin
         sdata_q <= `SSP_LINK_IDLE;
      end
      else if (idx_q < IW'(W))
      begin
         sdata_q <= cap_q[(W - 1) - int'(idx_q)];
      end
      else
      begin
         sdata_q <= `SSP_SURPLUS_BIT;
      end
   end

   assign link.sdata = sdata_q;

endmodule

// ---- ssp_map.svh ----
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// ***************************************
// Clock and timing
// ***************************************
`define SSP_CLK_SYS_MHZ 250
`define SSP_MONOFLOP_US 12
`define SSP_PAUSE_US 16
`define SSP_SCLK_MIN_KHZ 100
`define SSP_SCLK_MAX_KHZ 1000
`define SSP_SCLK_DEF_KHZ 250
`define SSP_LINK_CLR_CYC 2

// ***************************************
// Word lengths per resolution variant
// ***************************************
`define SSP_WLEN_50UM 19
`define SSP_WLEN_10UM 21
`define SSP_WLEN_5UM 22
`define SSP_WLEN_2UM 23
`define SSP_WLEN_1UM 24

// ***************************************
// Word layout and line levels
// ***************************************
`define SSP_FAULT_BIT 0
`define SSP_LINK_IDLE 1'b1
`define SSP_SURPLUS_BIT 1'b0

`endif

// ---- ssp_pkg.sv ----
`include "ssp_map.svh"

package ssp_pkg;

   // Output code of the position field, fixed per build
   typedef enum logic {SSP_CODE_BINARY, SSP_CODE_GRAY} ssp_code_t;

   // Master burst sequencer
   typedef enum logic [2:0] {MS_IDLE, MS_LOW, MS_HIGH, MS_DONE, MS_PAUSE} ssp_mst_state_t;

   // Total word length, fault bit included, for a resolution in micrometres
   function automatic int ssp_word_len(input int res_um);
      case (res_um)
         50: return `SSP_WLEN_50UM;
         10: return `SSP_WLEN_10UM;
         5: return `SSP_WLEN_5UM;
         2: return `SSP_WLEN_2UM;
         default: return `SSP_WLEN_1UM;
      endcase
   endfunction

endpackage

// ---- ssp_link_if.sv ----
interface ssp_link_if;
   // Serial clock, made by the master, high while idle
   logic sclk;
   // Serial data, driven by the encoder end
   logic sdata;

   modport dev (input sclk, output sdata);
   modport mst (output sclk, input sdata);
endinterface

// ---- ssp_ssi_master.sv ----
`include "ssp_map.svh"

module ssp_ssi_master
   import ssp_pkg::*;
#(
   parameter int RES_UM = 1,
   parameter ssp_code_t CODE = SSP_CODE_GRAY,
   parameter int SCLK_KHZ = `SSP_SCLK_DEF_KHZ,
   parameter int NCLK = ssp_word_len(RES_UM) + 1,
   localparam int W = ssp_word_len(RES_UM)
)
(
   // System side
   input wire logic clk_sys,
   input wire logic reset,
   // Request and answer
   input wire logic start,
   output logic ready,
   output logic done,
   output logic [W-2:0] position,
   output logic no_fault,
   // Link
   ssp_link_if.mst link
);

   localparam int HALF_CYC = (`SSP_CLK_SYS_MHZ * 1000) / (2 * SCLK_KHZ);
   localparam int PAUSE_CYC = `SSP_PAUSE_US * `SSP_CLK_SYS_MHZ + 1;
   localparam int TW = $clog2(PAUSE_CYC + 1);
   localparam int PCW = $clog2(NCLK + 1);

   function automatic logic [W-2:0] gray_to_bin(input logic [W-2:0] g);
      logic [W-2:0] b;
      b = '0;
      b[W-2] = g[W-2];
      for (int i = W - 3; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // ***************************************
   // Data input synchroniser
   // ***************************************
   logic sd_s1_q;
   logic sd_s2_q;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         sd_s1_q <= `SSP_LINK_IDLE;
         sd_s2_q <= `SSP_LINK_IDLE;
      end
      else
      begin
         sd_s1_q <= link.sdata;
         sd_s2_q <= sd_s1_q;
      end
   end

   // ***************************************
   // Burst sequencer
   // ***************************************
   ssp_mst_state_t state_q;
   logic [TW-1:0] tmr_q;
   logic [PCW-1:0] pulse_q;
   logic sclk_q;
   logic [W-1:0] shreg_q;
   logic tmr_zero;

   assign tmr_zero = (tmr_q == '0);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state_q <= MS_IDLE;
         tmr_q <= '0;
         pulse_q <= '0;
         sclk_q <= `SSP_LINK_IDLE;
      end
      else
      begin
         unique case (state_q)
            MS_IDLE:
            begin
               if (start)
               begin
                  state_q <= MS_LOW;
                  sclk_q <= 1'b0;
                  tmr_q <= TW'(HALF_CYC - 1);
                  pulse_q <= PCW'(1);
               end
            end
            MS_LOW:
            begin
               if (tmr_zero)
               begin
                  state_q <= MS_HIGH;
                  sclk_q <= 1'b1;
                  tmr_q <= TW'(HALF_CYC - 1);
               end
               else
               begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            MS_HIGH:
            begin
               if (!tmr_zero)
               begin
                  tmr_q <= tmr_q - 1'b1;
               end
               else if (pulse_q == PCW'(NCLK))
               begin
                  state_q <= MS_DONE;
               end
               else
               begin
                  state_q <= MS_LOW;
                  sclk_q <= 1'b0;
                  tmr_q <= TW'(HALF_CYC - 1);
                  pulse_q <= pulse_q + 1'b1;
               end
            end
            MS_DONE:
            begin
               state_q <= MS_PAUSE;
               tmr_q <= TW'(PAUSE_CYC - 1);
            end
            MS_PAUSE:
            begin
               if (tmr_zero)
               begin
                  state_q <= MS_IDLE;
               end
               else
               begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            default:
            begin
               state_q <= MS_IDLE;
            end
         endcase
      end
   end

   assign link.sclk = sclk_q;

   // ***************************************
   // Bit sampling, at the end of each of the first W high phases
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         shreg_q <= '0;
      end
      else if (state_q == MS_HIGH && tmr_zero && pulse_q <= PCW'(W))
      begin
         shreg_q <= {shreg_q[W-2:0], sd_s2_q};
      end
   end

   // ***************************************
   // Answer
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         done <= 1'b0;
         position <= '0;
         no_fault <= 1'b0;
         ready <= 1'b0;
      end
      else
      begin
         done <= (state_q == MS_DONE);
         ready <= (state_q == MS_IDLE) && !start;
         if (state_q == MS_DONE)
         begin
            no_fault <= shreg_q[`SSP_FAULT_BIT];
            position <= (CODE == SSP_CODE_GRAY) ? gray_to_bin(shreg_q[W-1:1]) : shreg_q[W-1:1];
         end
      end
   end

endmodule

// ---- ssp_link_properties.sv ----
module ssp_link_properties
(
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Link
   input wire logic sclk,
   input wire logic sdata,
   // Handshakes
   input wire logic ready,
   input wire logic start,
   input wire logic done
);
   logic sclk_q;
   logic [11:0] quiet_q;
   logic burst_run_q;
   logic [12:0] burst_cnt_q;

   // ***************************************
   // Cycles since an accepted burst request
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         burst_run_q <= 1'b0;
         burst_cnt_q <= 13'h0000;
      end
      else if (start && ready && sclk && !burst_run_q)
      begin
         burst_run_q <= 1'b1;
         burst_cnt_q <= 13'h0000;
      end
      else if (done)
      begin
         burst_run_q <= 1'b0;
      end
      else if (burst_run_q && burst_cnt_q != 13'h1FFF)
      begin
         burst_cnt_q <= burst_cnt_q + 13'h0001;
      end
   end

   // ***************************************
   // Cycles since the last link clock change
   // ***************************************
   always_ff @(posedge clk_sys)
   begin
      sclk_q <= sclk;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         quiet_q <= 12'hFFF;
      else if (sclk != sclk_q)
         quiet_q <= 12'h000;
      else if (quiet_q != 12'hFFF)
         quiet_q <= quiet_q + 12'h001;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // ***************************************
   // Assertions
   // ***************************************
   a_idle_line_high: assert property (ready |-> sdata)
      else $error("data line low while ready");
   a_capture_busy: assert property ($fell(sclk) && ready |-> ##[1:6] !ready)
      else $error("burst start not taken");
   a_busy_in_burst: assert property ($rose(sclk) |-> ##1 !ready [*8])
      else $error("ready during burst");
   a_ready_delay: assert property ($rose(ready) && quiet_q < 12'hFA0 |-> quiet_q >= 12'hBAE)
      else $error("ready before monoflop interval");
   a_pause_kept: assert property ($fell(sclk) && quiet_q > 12'h0C8 |-> quiet_q > 12'hFA0)
      else $error("pause between bursts too short");
   a_rate_bound: assert property ($changed(sclk) |-> quiet_q >= 12'h07C)
      else $error("link clock phase too short");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_done_clk_high: assert property (done |-> sclk)
      else $error("link clock low after burst");
   a_burst_length: assert property (done |-> burst_run_q && burst_cnt_q >= 13'h144F && burst_cnt_q <= 13'h14B3)
      else $error("burst length wrong");
   a_burst_ends: assert property (burst_run_q |-> burst_cnt_q <= 13'h14B3)
      else $error("burst did not end in time");

   cover property (burst_run_q && done);
   cover property ($rose(ready));
   cover property ($fell(sclk) && ready);
endmodule

// ---- ssi_position_slave_tb.sv ----
`define CHK(a, b) \
   begin \
      checks_done++; \
      if ((a) !== (b)) \
      begin \
         n_fail++; \
         $display("unexpected t=%0t got %h exp %h", $time, a, b); \
      end \
   end

module ssi_position_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssp_pkg::*;

   localparam int RES = 50;
   localparam int W = ssp_word_len(RES);
   localparam int NCLK = W + 2;

   logic clk_sys, reset, start, read_fault, speed_fault;
   logic [W-2:0] pos_in, pos_out;
   logic dev_ready, mst_ready, done, no_fault;
   int n_fail, checks_done;

   ssp_link_if link ();

   ssp_ssi_slave #(.RES_UM(RES), .CODE(SSP_CODE_GRAY)) ssp_ssi_slave_i (.clk_sys(clk_sys), .reset(reset),
      .position(pos_in), .read_fault(read_fault), .speed_fault(speed_fault), .ready(dev_ready), .link(link));

   ssp_ssi_master #(.RES_UM(RES), .CODE(SSP_CODE_GRAY), .SCLK_KHZ(1000), .NCLK(NCLK)) ssp_ssi_master_i (
      .clk_sys(clk_sys), .reset(reset), .start(start), .ready(mst_ready), .done(done),
      .position(pos_out), .no_fault(no_fault), .link(link));

   ssp_link_properties ssp_link_properties_i (.clk_sys(clk_sys), .reset(reset), .sclk(link.sclk),
      .sdata(link.sdata), .ready(dev_ready), .start(start), .done(done));

   // ***************************************
   // Expectations and bus tasks
   // ***************************************
   function automatic logic [W-1:0] exp_word(input logic [W-2:0] p, input logic rf, input logic sf);
      return {p ^ (p >> 1), ~(rf | sf)};
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wait_idle();
      int k;
      for (k = 0; k < 6000 && !(mst_ready === 1'b1 && dev_ready === 1'b1); k++)
         @(negedge clk_sys);
      `CHK(dev_ready & mst_ready, 1'b1)
      `CHK(link.sdata, 1'b1)
   endtask

   task automatic xfer(input logic [W-2:0] p, input logic rf, input logic sf, input bit poke);
      logic [W-1:0] rx;
      int k;
      @(negedge clk_sys);
      pos_in = p;
      read_fault = rf;
      speed_fault = sf;
      @(negedge clk_sys);
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      pos_in = p + 1'b1;
      for (k = W - 1; k >= 0; k--)
      begin
         @(negedge link.sclk);
         rx[k] = link.sdata;
         if (poke && k == 10)
         begin
            @(negedge clk_sys);
            start = 1'b1;
            @(negedge clk_sys);
            start = 1'b0;
         end
      end
      @(negedge link.sclk);
      `CHK(link.sdata, 1'b0)
      @(posedge link.sclk);
      repeat (20) @(negedge clk_sys);
      `CHK(link.sdata, 1'b0)
      `CHK(rx, exp_word(p, rf, sf))
      for (k = 0; k < 400 && done !== 1'b1; k++)
         @(negedge clk_sys);
      `CHK(done, 1'b1)
      `CHK(pos_out, p)
      `CHK(no_fault, ~(rf | sf))
      wait_idle();
   endtask

   // ***************************************
   // Clock, stimulus, watchdog
   // ***************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial
   begin
      reset = 1'b1;
      start = 1'b0;
      pos_in = '0;
      read_fault = 1'b0;
      speed_fault = 1'b0;
      n_fail = 0;
      checks_done = 0;
      void'($urandom(32'hB7C6));
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      `CHK(link.sclk, 1'b1)
      wait_idle();
      xfer('0, 1'b0, 1'b0, 1'b0);
      xfer('1, 1'b1, 1'b0, 1'b1);
      xfer(18'h2AAAA, 1'b0, 1'b1, 1'b0);
      repeat (3) xfer((W-1)'($urandom), 1'($urandom), 1'($urandom), 1'b0);
      results();
   end

   initial
   begin
      repeat (80000) @(posedge clk_sys);
      n_fail++;
      results();
   end
endmodule
